//--- logic/ssp_pkg.sv
// ssp_pkg: register map, field layouts, reset values and carrier types for the serial port
package ssp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0C;
  localparam logic [7:0] OFS_RXDATA = 8'h10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] CTRL_RESET = 32'h0100_0000;
  localparam logic [31:0] PORT_RESET = 32'h0000_0000;
  localparam logic [23:0] DATA_RESET = 24'h00_0000;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // ************************************************************
  // status bit positions
  // ************************************************************
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_TX_UNDER = 2;
  localparam int ST_RX_OVER = 3;
  localparam int ST_FLAG_ZERO = 4;
  localparam int ST_FLAG_ONE = 5;
  localparam int ST_GPIO_LSB = 8;

  // ************************************************************
  // word geometry: index of last bit per word length
  // ************************************************************
  localparam logic [4:0] LAST_BIT_8 = 5'h07;
  localparam logic [4:0] LAST_BIT_12 = 5'h0B;
  localparam logic [4:0] LAST_BIT_16 = 5'h0F;
  localparam logic [4:0] LAST_BIT_24 = 5'h17;
  localparam logic [4:0] SLOT_FIRST = 5'h00;

  // ************************************************************
  // modes and carriers
  // ************************************************************
  typedef enum logic [1:0] {MODE_NORMAL, MODE_NETWORK, MODE_ON_DEMAND, MODE_SPARE} ssp_mode_e;
  typedef enum logic [1:0] {LEN_8, LEN_12, LEN_16, LEN_24} ssp_len_e;

  typedef struct packed {
    logic [7:0] clkDiv;
    logic [3:0] spare;
    logic [1:0] flagOut;
    logic rxEnable;
    logic txEnable;
    logic bitclockDirection;
    logic ctrlTwoDirection;
    logic ctrlOneDirection;
    logic ctrlZeroDirection;
    logic clockGatingSelect;
    logic timingModeSelect;
    logic shiftOrderBit;
    logic [4:0] slotsLessOne;
    ssp_len_e wordLen;
    ssp_mode_e mode;
  } ssp_ctrl_s;

  typedef struct packed {
    logic [19:0] spare;
    logic [3:0] gpioDir;
    logic [3:0] gpioOut;
    logic [1:0] spareLow;
    logic ctrlSel;
    logic txSel;
  } ssp_port_s;

  typedef struct packed {
    logic o;
    logic oe;
  } ssp_pad_s;

endpackage : ssp_pkg

//--- logic/ssp_sync_edge.sv
// ssp_sync_edge: three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/10ps
module ssp_sync_edge
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cen,
  // pin side
  input wire logic pinIn,
  // clock domain side
  output logic level,
  output logic rise,
  output logic fall
);

  // ************************************************************
  // synchroniser and filtered level
  // ************************************************************
  logic [2:0] stage;
  logic agree;

  assign agree = (stage[1] == stage[2]);
  assign rise = agree & stage[2] & ~level;
  assign fall = agree & ~stage[2] & level;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage <= 3'h0;
      level <= 1'b0;
    end
    else if (cen)
    begin
      stage <= {stage[1:0], pinIn};
      if (agree)
      begin
        level <= stage[2];
      end
    end
  end

endmodule : ssp_sync_edge

//--- logic/ssp_core.sv
// ssp_core: synchronous serial port with pin routing, bit clock selection and ahb-lite registers
//
// Operation
// - normal mode: one word per frame
// - network mode: up to 32 slots per frame
// - on-demand: send words when data arrives
// - word length 8, 12, 16 or 24
// - four request outputs, plain and exception
// - drive transmit pin while shifting, one period more on internal clock
// - transmit data changes on clock rise
// - external gated clock: release on last fall
// - internal clock: release one period later
// - shift order bit selects msb or lsb
// - transmit pin is gpio when unselected
// - synchronous: clock pin clocks both directions
// - asynchronous: receive clock on pin zero
// - control pins serial only when selected
// - direction bit zero input, one output
// - asynchronous pin roles: clock, syncs
// - bit clock sources per mode and direction
// - receiver samples on falling clock edge
`timescale 1ns/10ps
module ssp_core
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cen,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pins
  output ssp_pad_s txDataPin,
  input wire logic rxDataPin,
  input wire logic serialClockPinIn,
  output ssp_pad_s serialClockPin,
  input wire logic ctrlPinZeroIn,
  output ssp_pad_s ctrlPinZero,
  input wire logic ctrlPinOneIn,
  output ssp_pad_s ctrlPinOne,
  input wire logic ctrlPinTwoIn,
  output ssp_pad_s ctrlPinTwo,
  // requests
  output logic rxReq,
  output logic rxExcReq,
  output logic txReq,
  output logic txExcReq
);

  // ************************************************************
  // registers and bus decode
  // ************************************************************
  ssp_ctrl_s ctrl;
  ssp_port_s port;
  logic [23:0] txData;
  logic [23:0] rxData;
  logic txHave;
  logic rxFull;
  logic txUnder;
  logic rxOver;
  logic wrPend;
  logic [7:0] wrAddr;
  logic addrOk;
  logic rxRead;
  logic [31:0] readValue;
  logic [3:0] gpioIn;

  assign addrOk = hsel && htrans[1] && hready;
  assign rxRead = addrOk && !hwrite && (haddr[7:0] == OFS_RXDATA);

  always_comb
  begin
    readValue = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: readValue = ctrl;
      OFS_PORT: readValue = port;
      OFS_STATUS:
      begin
        readValue[ST_TX_EMPTY] = !txHave;
        readValue[ST_RX_FULL] = rxFull;
        readValue[ST_TX_UNDER] = txUnder;
        readValue[ST_RX_OVER] = rxOver;
        readValue[ST_FLAG_ZERO] = gpioIn[1];
        readValue[ST_FLAG_ONE] = gpioIn[2];
        readValue[ST_GPIO_LSB +: 4] = gpioIn;
      end
      OFS_TXDATA: readValue = {8'h00, txData};
      OFS_RXDATA: readValue = {8'h00, rxData};
      default: readValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (cen)
    begin
      wrPend <= addrOk && hwrite;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrOk)
      begin
        wrAddr <= haddr[7:0];
      end
      if (addrOk && !hwrite)
      begin
        hrdata <= readValue;
      end
    end
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic sckLvl, sckRise, sckFall;
  logic c0Lvl, c0Rise, c0Fall;
  logic c1Lvl, c2Lvl, rxdLvl;

  ssp_sync_edge uSyncSck (.ref_clk(ref_clk), .resetn(resetn), .cen(cen),
    .pinIn(serialClockPinIn), .level(sckLvl), .rise(sckRise), .fall(sckFall));
  ssp_sync_edge uSyncC0 (.ref_clk(ref_clk), .resetn(resetn), .cen(cen),
    .pinIn(ctrlPinZeroIn), .level(c0Lvl), .rise(c0Rise), .fall(c0Fall));
  ssp_sync_edge uSyncC1 (.ref_clk(ref_clk), .resetn(resetn), .cen(cen),
    .pinIn(ctrlPinOneIn), .level(c1Lvl), .rise(), .fall());
  ssp_sync_edge uSyncC2 (.ref_clk(ref_clk), .resetn(resetn), .cen(cen),
    .pinIn(ctrlPinTwoIn), .level(c2Lvl), .rise(), .fall());
  ssp_sync_edge uSyncRxd (.ref_clk(ref_clk), .resetn(resetn), .cen(cen),
    .pinIn(rxDataPin), .level(rxdLvl), .rise(), .fall());

  assign gpioIn = {c2Lvl, c1Lvl, c0Lvl, 1'b0};

  // ************************************************************
  // clock and frame routing
  // ************************************************************
  logic txActive, txLinger, txDrive, txFsOut, rxActive, rxFsOut;
  logic [4:0] txBit, txSlot, rxBit, rxSlot;
  logic [23:0] txShift, rxShift;
  logic [7:0] divCnt;
  logic intClk, intRun, intRise, intFall;
  logic syncT, ctrlOn, gated, onDemand;
  logic txRise, txFall, rxFall, txIntClk;
  logic txFsExt, rxFsLvl, rxSelfFramed;
  logic [4:0] lastBit, lastSlot;

  assign syncT = ctrl.timingModeSelect;
  assign ctrlOn = port.ctrlSel;
  assign gated = ctrl.clockGatingSelect;
  assign onDemand = (ctrl.mode == MODE_ON_DEMAND);
  assign lastSlot = (ctrl.mode == MODE_NETWORK) ? ctrl.slotsLessOne : SLOT_FIRST;

  always_comb
  begin
    case (ctrl.wordLen)
      LEN_8: lastBit = LAST_BIT_8;
      LEN_12: lastBit = LAST_BIT_12;
      LEN_16: lastBit = LAST_BIT_16;
      default: lastBit = LAST_BIT_24;
    endcase
  end

  // internal bit clock, stopped between words when gated
  assign intRun = (ctrl.txEnable || ctrl.rxEnable) && (!gated || txHave || txActive || txLinger);
  assign intRise = intRun && (divCnt == ctrl.clkDiv) && !intClk;
  assign intFall = intRun && (divCnt == ctrl.clkDiv) && intClk;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt <= DIV_RESET;
      intClk <= 1'b0;
    end
    else if (cen)
    begin
      if (!intRun)
      begin
        divCnt <= DIV_RESET;
        intClk <= 1'b0;
      end
      else if (divCnt == ctrl.clkDiv)
      begin
        divCnt <= DIV_RESET;
        intClk <= ~intClk;
      end
      else
      begin
        divCnt <= divCnt + 8'h01;
      end
    end
  end

  assign txIntClk = ctrl.bitclockDirection;
  assign txRise = txIntClk ? intRise : sckRise;
  assign txFall = txIntClk ? intFall : sckFall;
  assign rxFall = syncT ? txFall :
    (ctrl.ctrlZeroDirection ? intFall : (ctrlOn && c0Fall));
  assign txFsExt = ctrlOn && !ctrl.ctrlTwoDirection && !gated && c2Lvl;
  assign rxSelfFramed = !syncT && ctrlOn && ctrl.ctrlOneDirection;
  assign rxFsLvl = syncT ? (ctrl.ctrlTwoDirection ? txFsOut : txFsExt) :
    (ctrlOn && !ctrl.ctrlOneDirection && !gated && c1Lvl);

  // ************************************************************
  // transmitter
  // ************************************************************
  logic txRun, txLastBit, txBoundary, txStartOk, txStart, txLoad, txUnderSet;
  logic [4:0] txNextSlot;

  assign txRun = ctrl.txEnable && port.txSel;
  assign txLastBit = txActive && (txBit == lastBit);
  assign txBoundary = !txActive || txLastBit;
  assign txNextSlot = (txActive && (txSlot != lastSlot)) ? txSlot + 5'h01 : SLOT_FIRST;

  always_comb
  begin
    if (gated)
    begin
      txStartOk = txIntClk ? txHave : 1'b1;
    end
    else if (onDemand)
    begin
      txStartOk = ctrl.ctrlTwoDirection ? txHave : (txHave && txFsExt);
    end
    else
    begin
      txStartOk = (txNextSlot != SLOT_FIRST) || ctrl.ctrlTwoDirection || txFsExt;
    end
  end

  assign txStart = txRun && txRise && txBoundary && txStartOk;
  assign txLoad = txStart && txHave;
  assign txUnderSet = txStart && !txHave && (ctrl.mode == MODE_NORMAL);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txActive <= 1'b0;
      txLinger <= 1'b0;
      txDrive <= 1'b0;
      txFsOut <= 1'b0;
      txBit <= SLOT_FIRST;
      txSlot <= SLOT_FIRST;
      txShift <= DATA_RESET;
    end
    else if (cen)
    begin
      if (!txRun)
      begin
        txActive <= 1'b0;
        txLinger <= 1'b0;
        txDrive <= 1'b0;
        txFsOut <= 1'b0;
      end
      else if (txStart)
      begin
        txActive <= 1'b1;
        txLinger <= 1'b0;
        txBit <= SLOT_FIRST;
        txSlot <= txNextSlot;
        txFsOut <= (txNextSlot == SLOT_FIRST);
        txDrive <= txHave || (ctrl.mode == MODE_NORMAL);
        if (ctrl.shiftOrderBit)
        begin
          txShift <= txHave ? txData : DATA_RESET;
        end
        else
        begin
          txShift <= txHave ? (txData << (LAST_BIT_24 - lastBit)) : DATA_RESET;
        end
      end
      else if (txRise && txActive && !txLastBit)
      begin
        txBit <= txBit + 5'h01;
        txFsOut <= 1'b0;
        txShift <= ctrl.shiftOrderBit ? (txShift >> 1) : (txShift << 1);
      end
      else if (txRise && txLastBit)
      begin
        txActive <= 1'b0;
        txFsOut <= 1'b0;
        txLinger <= txIntClk && txDrive;
        txDrive <= txIntClk && txDrive;
      end
      else if (txRise && txLinger)
      begin
        txLinger <= 1'b0;
        txDrive <= 1'b0;
      end
      else if (txFall && txLastBit && gated && !txIntClk)
      begin
        txDrive <= 1'b0;
      end
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  logic rxLastBit, rxBoundary, rxStartOk, rxStart, rxTake, rxDone;
  logic [4:0] rxNextSlot;
  logic [23:0] rxShiftNext, rxWord;

  assign rxLastBit = rxActive && (rxBit == lastBit);
  assign rxBoundary = !rxActive || rxLastBit;
  assign rxNextSlot = (rxActive && (rxSlot != lastSlot)) ? rxSlot + 5'h01 : SLOT_FIRST;
  assign rxStartOk = gated || (rxNextSlot != SLOT_FIRST) || rxSelfFramed || rxFsLvl;
  assign rxStart = ctrl.rxEnable && rxFall && rxBoundary && rxStartOk;
  assign rxTake = ctrl.rxEnable && rxFall && (rxStart || (rxActive && !rxLastBit));
  assign rxDone = rxTake && !rxStart && ((rxBit + 5'h01) == lastBit);
  assign rxShiftNext = ctrl.shiftOrderBit ? {rxdLvl, rxShift[23:1]} : {rxShift[22:0], rxdLvl};
  assign rxWord = ctrl.shiftOrderBit ? (rxShiftNext >> (LAST_BIT_24 - lastBit)) :
    (rxShiftNext & ~(24'hFF_FFFF << (lastBit + 5'h01)));

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxActive <= 1'b0;
      rxFsOut <= 1'b0;
      rxBit <= SLOT_FIRST;
      rxSlot <= SLOT_FIRST;
      rxShift <= DATA_RESET;
    end
    else if (cen)
    begin
      if (!ctrl.rxEnable)
      begin
        rxActive <= 1'b0;
        rxFsOut <= 1'b0;
      end
      else if (rxStart)
      begin
        rxActive <= 1'b1;
        rxBit <= SLOT_FIRST;
        rxSlot <= rxNextSlot;
        rxFsOut <= (rxNextSlot == SLOT_FIRST);
        rxShift <= rxShiftNext;
      end
      else if (rxTake)
      begin
        rxBit <= rxBit + 5'h01;
        rxFsOut <= 1'b0;
        rxShift <= rxShiftNext;
      end
      else if (rxFall && rxLastBit)
      begin
        rxActive <= 1'b0;
      end
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  logic wrCtrl, wrPort, wrStatus, wrTx;

  assign wrCtrl = wrPend && (wrAddr == OFS_CTRL);
  assign wrPort = wrPend && (wrAddr == OFS_PORT);
  assign wrStatus = wrPend && (wrAddr == OFS_STATUS);
  assign wrTx = wrPend && (wrAddr == OFS_TXDATA);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl <= CTRL_RESET;
      port <= PORT_RESET;
      txData <= DATA_RESET;
      rxData <= DATA_RESET;
      txHave <= 1'b0;
      rxFull <= 1'b0;
      txUnder <= 1'b0;
      rxOver <= 1'b0;
    end
    else if (cen)
    begin
      if (wrCtrl)
      begin
        ctrl <= hwdata;
      end
      if (wrPort)
      begin
        port <= hwdata;
      end
      if (wrTx)
      begin
        txData <= hwdata[23:0];
      end
      if (rxDone)
      begin
        rxData <= rxWord;
      end
      txHave <= (txHave && !txLoad) || wrTx;
      rxFull <= (rxFull && !rxRead) || rxDone;
      txUnder <= (txUnder && !(wrStatus && hwdata[ST_TX_UNDER])) || txUnderSet;
      rxOver <= (rxOver && !(wrStatus && hwdata[ST_RX_OVER])) || (rxDone && rxFull);
    end
  end

  // ************************************************************
  // pin drivers and requests
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txDataPin <= 2'b00;
      serialClockPin <= 2'b00;
      ctrlPinZero <= 2'b00;
      ctrlPinOne <= 2'b00;
      ctrlPinTwo <= 2'b00;
      rxReq <= 1'b0;
      rxExcReq <= 1'b0;
      txReq <= 1'b0;
      txExcReq <= 1'b0;
    end
    else if (cen)
    begin
      if (port.txSel)
      begin
        txDataPin.o <= ctrl.shiftOrderBit ? txShift[0] : txShift[23];
        txDataPin.oe <= txDrive;
      end
      else
      begin
        txDataPin <= {port.gpioOut[0], port.gpioDir[0]};
      end
      serialClockPin.o <= intClk;
      serialClockPin.oe <= ctrl.bitclockDirection && (ctrl.txEnable || ctrl.rxEnable);
      if (ctrlOn)
      begin
        ctrlPinZero.o <= syncT ? ctrl.flagOut[0] : intClk;
        ctrlPinZero.oe <= ctrl.ctrlZeroDirection;
        ctrlPinOne.o <= syncT ? ctrl.flagOut[1] : rxFsOut;
        ctrlPinOne.oe <= ctrl.ctrlOneDirection;
        ctrlPinTwo.o <= txFsOut;
        ctrlPinTwo.oe <= ctrl.ctrlTwoDirection;
      end
      else
      begin
        ctrlPinZero <= {port.gpioOut[1], port.gpioDir[1]};
        ctrlPinOne <= {port.gpioOut[2], port.gpioDir[2]};
        ctrlPinTwo <= {port.gpioOut[3], port.gpioDir[3]};
      end
      rxReq <= ctrl.rxEnable && rxFull && !rxOver;
      rxExcReq <= ctrl.rxEnable && rxFull && rxOver;
      txReq <= txRun && !txHave && !txUnder;
      txExcReq <= txRun && !txHave && txUnder;
    end
  end

endmodule : ssp_core

//--- verif/ssp_core_properties.sv
// ssp_core_properties: bus and pin timing checks for ssp_core
`timescale 1ns/10ps
module ssp_core_properties
  import ssp_pkg::*;
(
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins and requests
  input wire ssp_pad_s txDataPin,
  input wire ssp_pad_s serialClockPin,
  input wire logic rxReq,
  input wire logic rxExcReq,
  input wire logic txReq,
  input wire logic txExcReq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic rdTaken;
  assign rdTaken = hsel && htrans[1] && hready && !hwrite;
  // ****
  // checks
  // ****
  bus_ready_a: assert property (hreadyout && !hresp)
    else $error("bus wait or error seen");
  read_hold_a: assert property (!rdTaken |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rdTaken && haddr[7:0] == 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rx_excl_a: assert property (!(rxReq && rxExcReq))
    else $error("both receive requests high");
  tx_excl_a: assert property (!(txReq && txExcReq))
    else $error("both transmit requests high");
  rx_clear_a: assert property (rdTaken && haddr[7:0] == OFS_RXDATA && rxReq |-> ##[1:2] !rxReq)
    else $error("receive request not cleared by read");
  tx_edge_a: assert property (txDataPin.oe && $past(txDataPin.oe) && serialClockPin.oe
    && $changed(txDataPin.o) |-> serialClockPin.o)
    else $error("transmit data changed off the rising half");
  tx_release_a: assert property ($fell(txDataPin.oe) && serialClockPin.oe |-> serialClockPin.o)
    else $error("transmit pin released off a rising edge");
endmodule : ssp_core_properties
bind ssp_core ssp_core_properties u_props (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .txDataPin, .serialClockPin, .rxReq, .rxExcReq,
  .txReq, .txExcReq);

//--- verif/ssp_codec_model.sv
// ssp_codec_model: codec driving a gated external bit clock
`timescale 1ns/10ps
module ssp_codec_model
(
  // frame request and data
  input wire logic go,
  input wire logic [7:0] word,
  input wire logic txd,
  // link side
  output logic sclk,
  output logic fs,
  output logic rxd,
  output logic [7:0] seen
);
  initial
  begin
    sclk = 1'b0;
    fs = 1'b0;
    rxd = 1'b0;
    seen = 8'h00;
  end
  // one frame, clock still outside it
  always @(posedge go)
  begin
    #113;
    for (int i = 0; i < 8; i++)
    begin
      sclk = 1'b1;
      fs = (i == 0);
      rxd = word[7 - i];
      #200 sclk = 1'b0;
      #150 seen = {seen[6:0], txd};
      #50;
    end
    fs = 1'b0;
    rxd = ~rxd;
  end
endmodule : ssp_codec_model

//--- verif/ssp_core_tb.sv
// ssp_core_tb: register and link tests for the serial port
`timescale 1ns/10ps
module ssp_core_tb
  import ssp_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic go = 1'b0;
  logic f1 = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rxReq, rxExcReq, txReq, txExcReq, sck, fs, rxd, mSck, txw;
  logic [7:0] seen;
  ssp_pad_s txDataPin, serialClockPin, ctrlPinZero, ctrlPinOne, ctrlPinTwo;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int nb[4] = '{8, 12, 16, 24};
  always #25 ref_clk = ~ref_clk;
  assign sck = serialClockPin.oe ? serialClockPin.o : mSck;
  assign txw = txDataPin.oe ? txDataPin.o : 1'bz;
  ssp_core DUT (.ref_clk, .resetn, .cen(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .txDataPin, .rxDataPin(rxd),
    .serialClockPinIn(sck), .serialClockPin,
    .ctrlPinZeroIn(ctrlPinZero.oe ? ctrlPinZero.o : f1), .ctrlPinZero,
    .ctrlPinOneIn(ctrlPinOne.oe ? ctrlPinOne.o : f1), .ctrlPinOne,
    .ctrlPinTwoIn(ctrlPinTwo.oe ? ctrlPinTwo.o : fs), .ctrlPinTwo,
    .rxReq, .rxExcReq, .txReq, .txExcReq);
  ssp_codec_model u_codec (.go, .word(8'h96), .txd(txw), .sclk(mSck), .fs, .rxd, .seen);
  // ****
  // tasks
  // ****
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      badCount++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input string s);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(s, e, q & m);
  endtask : rd
  task automatic grab(input int n, output logic [23:0] v);
    int k;
    logic p;
    k = 0;
    v = 24'h0;
    p = serialClockPin.o;
    while (k < n)
    begin
      @(posedge ref_clk);
      if (p && !serialClockPin.o && (k > 0 || ctrlPinTwo.o))
      begin
        v = {v[22:0], txDataPin.oe ? txDataPin.o : 1'bx};
        k++;
      end
      p = serialClockPin.o;
    end
  endtask : grab
  task automatic fsgap(output int g);
    g = 0;
    while (ctrlPinTwo.o)
      @(posedge ref_clk);
    while (!ctrlPinTwo.o)
      @(posedge ref_clk);
    do
    begin
      @(posedge ref_clk);
      g++;
    end
    while (ctrlPinTwo.o);
    do
    begin
      @(posedge ref_clk);
      g++;
    end
    while (!ctrlPinTwo.o);
  endtask : fsgap
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      badCount++;
      tallyAndFinish;
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    ssp_ctrl_s c;
    logic [31:0] q;
    logic [23:0] v;
    logic [23:0] e;
    logic [23:0] w;
    int b;
    int n;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_CTRL, CTRL_RESET, ALL, "ctrl");
    rd(OFS_PORT, PORT_RESET, ALL, "port");
    rd(OFS_STATUS, 32'h1, 32'h1, "tx empty");
    wr(8'h14, ALL);
    rd(8'h14, 32'h0, ALL, "unmapped");
    $display("test reset done");
    wr(OFS_PORT, 32'h0000_0110);
    chk("gpio tx high", 32'h3, {30'h0, txDataPin});
    wr(OFS_PORT, 32'h0000_0100);
    chk("gpio tx low", 32'h1, {30'h0, txDataPin});
    $display("test gpio done");
    wr(OFS_PORT, 32'h0000_0E00);
    chk("gpio ctrl oe", 32'h7, {29'h0, ctrlPinTwo.oe, ctrlPinOne.oe, ctrlPinZero.oe});
    c = CTRL_RESET;
    c.rxEnable = 1'b1;
    c.ctrlZeroDirection = 1'b1;
    c.ctrlTwoDirection = 1'b1;
    c.bitclockDirection = 1'b1;
    wr(OFS_CTRL, c);
    wr(OFS_PORT, 32'h0000_0002);
    q[3:0] = {serialClockPin.oe, ctrlPinTwo.oe, ctrlPinOne.oe, ctrlPinZero.oe};
    chk("async oe", 32'hD, {28'h0, q[3:0]});
    q[0] = ctrlPinZero.o;
    repeat (2) @(posedge ref_clk);
    chk("rx clock out", {31'h0, !q[0]}, {31'h0, ctrlPinZero.o});
    f1 <= 1'b1;
    c.timingModeSelect = 1'b1;
    c.flagOut = 2'h1;
    wr(OFS_CTRL, c);
    chk("flag zero out", 32'h3, {30'h0, ctrlPinZero});
    rd(OFS_STATUS, 32'h20, 32'h20, "flag one in");
    $display("test pins done");
    wr(OFS_PORT, 32'h0000_0003);
    w = 24'hC35A1E;
    for (int a = 0; a < 8; a++)
    begin
      n = nb[a[1:0]];
      c = CTRL_RESET;
      c.mode = MODE_ON_DEMAND;
      c.wordLen = ssp_len_e'(a[1:0]);
      c.shiftOrderBit = a[2];
      c.timingModeSelect = 1'b1;
      c.ctrlTwoDirection = 1'b1;
      c.bitclockDirection = 1'b1;
      c.txEnable = 1'b1;
      wr(OFS_CTRL, c);
      e = 24'h0;
      for (b = 0; b < n; b++)
        e[n - 1 - b] = a[2] ? w[b] : w[n - 1 - b];
      fork
        grab(n, v);
        wr(OFS_TXDATA, {8'h0, w});
      join
      chk("tx word", {8'h0, e}, {8'h0, v});
      repeat (4) @(posedge ref_clk);
      chk("tx linger", 32'h1, {31'h0, txDataPin.oe});
      repeat (6) @(posedge ref_clk);
      chk("tx release", 32'h0, {31'h0, txDataPin.oe});
      chk("tx request", 32'h1, {31'h0, txReq});
    end
    $display("test internal clock done");
    c.mode = MODE_NETWORK;
    c.wordLen = LEN_8;
    c.slotsLessOne = 5'h01;
    wr(OFS_CTRL, c);
    fsgap(n);
    chk("network frame", 32'h40, n);
    c.mode = MODE_NORMAL;
    wr(OFS_CTRL, c);
    fsgap(n);
    chk("normal frame", 32'h20, n);
    $display("test frame done");
    // park the port so the clock pin handover leaves no false edge
    wr(OFS_CTRL, CTRL_RESET);
    repeat (8) @(posedge ref_clk);
    c = CTRL_RESET;
    c.timingModeSelect = 1'b1;
    c.clockGatingSelect = 1'b1;
    c.txEnable = 1'b1;
    c.rxEnable = 1'b1;
    wr(OFS_CTRL, c);
    wr(OFS_TXDATA, 32'h3C);
    go <= 1'b1;
    repeat (80) @(posedge ref_clk);
    chk("codec saw", 32'h3C, {24'h0, seen});
    chk("tx gated release", 32'h0, {31'h0, txDataPin.oe});
    chk("rx request", 32'h1, {30'h0, rxExcReq, rxReq});
    rd(OFS_RXDATA, 32'h96, ALL, "rx word");
    repeat (2) @(posedge ref_clk);
    chk("rx cleared", 32'h0, {31'h0, rxReq});
    $display("test external clock done");
    tallyAndFinish;
  end
endmodule : ssp_core_tb
